//--- design/wdtr_clear_ctl.sv
// wdtr_clear_ctl: decides which software clear instructions are accepted.
// assumes at most one clear strobe per cycle.
`timescale 1ns/10ps
module wdtr_clear_ctl (
	wdtr_clr_if.ctl clr
);
	import wdtr_pkg::*;

	wdtr_pair_t last;

	always_comb begin
		if (!clr.enabled) begin
			clr.accept = 1'b0;
		end else if (clr.paired) begin
			clr.accept = (clr.first & (last != WDTR_LAST_FIRST)) |
				(clr.second & (last != WDTR_LAST_SECOND));
		end else begin
			clr.accept = clr.single;
		end
	end

	always_ff @(posedge clr.core_clk) begin
		if (!clr.reset_n) begin
			last <= WDTR_LAST_NONE;
		end else if (clr.accept && clr.paired) begin
			last <= clr.first ? WDTR_LAST_FIRST : WDTR_LAST_SECOND;
		end
	end

	a_pair_repeat: assert property (@(posedge clr.core_clk) disable iff (!clr.reset_n)
		(clr.paired && last == WDTR_LAST_FIRST && clr.first && !clr.second) |-> !clr.accept)
		else $error("repeated first clear was accepted");
	a_pair_second: assert property (@(posedge clr.core_clk) disable iff (!clr.reset_n)
		(clr.paired && last == WDTR_LAST_SECOND && clr.second && !clr.first) |-> !clr.accept)
		else $error("repeated second clear was accepted");
	a_single_clear: assert property (@(posedge clr.core_clk) disable iff (!clr.reset_n)
		(clr.enabled && !clr.paired && clr.single) |-> clr.accept)
		else $error("single clear not accepted");
endmodule

//--- design/wdtr_sync_edge.sv
// wdtr_sync_edge: two-flop synchronisers with rising-edge pulses for the oscillator and reset pins.
// assumes inputs are asynchronous to core_clk and much slower than it.
`timescale 1ns/10ps
module wdtr_sync_edge (
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire logic [2:0] async_in,
	output logic      [2:0] level,
	output logic      [2:0] rise
);
	import wdtr_pkg::*;

	logic [2:0] meta;
	logic [2:0] prev;

	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_lane
			always_ff @(posedge core_clk) begin
				if (!reset_n) begin
					meta[i]  <= 1'b0;
					level[i] <= 1'b0;
					prev[i]  <= 1'b0;
				end else begin
					meta[i]  <= async_in[i];
					level[i] <= meta[i];
					prev[i]  <= level[i];
				end
			end
			assign rise[i] = level[i] & ~prev[i];
		end
	endgenerate
endmodule

//--- design/wdtr_top.sv
// wdtr_top: watchdog counter, control/status/config registers on apb, reset requests.
// assumes cpu strobes and mode levels are on core_clk; oscillator and reset pins are asynchronous.
// Summary of operation
// - watchdog clock is sub clock or sysclk/4
// - sub clock from crystal or rc oscillator
// - timeout is 2^(8+code) watchdog clock periods
// - key other than 1010 keeps watchdog running
// - disabled only if option off and key 1010
// - key field resets to 1010
// - disabled watchdog ignores its clears; halt still sets power-down
// - overflow in normal mode: full reset, flag
// - overflow in low power: pc/sp reset, flag
// - pin low, accepted clear, halt clear counter
// - option picks single or paired clear
// - paired clears must alternate to count
// - bit 7 keeps system clock in idle
// - sysclk source stops when system clock stops
// - clear sets power-down off, halt sets it
// - idle with clock on: halt clears, resumes
`timescale 1ns/10ps
module wdtr_top (
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        low_speed_crystal_osc,
	input  wire logic        low_speed_rc_osc,
	input  wire logic        external_reset_pin_n,
	input  wire logic        clear_single_instr,
	input  wire logic        clear_pair_first_instr,
	input  wire logic        clear_pair_second_instr,
	input  wire logic        halt_instr,
	input  wire logic        sleep_mode,
	input  wire logic        idle_mode,
	output logic             system_clock_run,
	output logic             device_reset_req,
	output logic             pc_sp_reset_req,
	output logic             timeout_flag,
	output logic             power_down_flag,
	output logic             watchdog_enabled
);
	import wdtr_pkg::*;

	logic [7:0]            watchdog_control;
	logic [3:0]            watchdog_config;
	logic [WDTR_CNT_W-1:0] count;
	logic [WDTR_CNT_W-1:0] mask;
	logic [1:0]            prediv;
	logic [2:0]            pin_level;
	logic [2:0]            pin_rise;
	logic [2:0]            tsel;
	logic [3:0]            soft_enable_key;
	logic                  idle_sysclk_keep_on;
	logic                  cfg_enable;
	logic                  cfg_src_sys;
	logic                  cfg_sub_rc;
	logic                  cfg_paired;
	logic                  enabled;
	logic                  low_power;
	logic                  sys_run;
	logic                  sys_tick;
	logic                  sub_tick;
	logic                  watchdog_clock;
	logic                  clear_cnt;
	logic                  overflow;
	logic                  accept;
	logic                  apb_setup;
	logic                  apb_write;
	logic                  hit_ctrl;
	logic                  hit_stat;
	logic                  hit_cfg;

	wdtr_sync_edge u_sync (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.async_in ({external_reset_pin_n, low_speed_rc_osc, low_speed_crystal_osc}),
		.level    (pin_level),
		.rise     (pin_rise)
	);

	wdtr_clr_if u_clr_if (
		.core_clk (core_clk),
		.reset_n  (reset_n)
	);

	assign u_clr_if.single  = clear_single_instr;
	assign u_clr_if.first   = clear_pair_first_instr;
	assign u_clr_if.second  = clear_pair_second_instr;
	assign u_clr_if.enabled = enabled;
	assign u_clr_if.paired  = cfg_paired;
	assign accept           = u_clr_if.accept;

	wdtr_clear_ctl u_clear (
		.clr (u_clr_if.ctl)
	);

	// field views
	assign idle_sysclk_keep_on = watchdog_control[WDTR_KEEP_ON_BIT];
	assign tsel                = watchdog_control[WDTR_TSEL_MSB:WDTR_TSEL_LSB];
	assign soft_enable_key     = watchdog_control[WDTR_KEY_MSB:0];
	assign cfg_enable          = watchdog_config[WDTR_CFG_EN_BIT];
	assign cfg_src_sys         = watchdog_config[WDTR_CFG_SYS_BIT];
	assign cfg_sub_rc          = watchdog_config[WDTR_CFG_RC_BIT];
	assign cfg_paired          = watchdog_config[WDTR_CFG_PAIR_BIT];

	// option enable wins; otherwise only the off key disables
	assign enabled = cfg_enable | (soft_enable_key != WDTR_KEY_OFF);

	assign low_power = sleep_mode | idle_mode;
	assign sys_run   = ~(sleep_mode | (idle_mode & ~idle_sysclk_keep_on));

	// system clock divided by four, held at zero while the system clock is stopped
	always_ff @(posedge core_clk) begin
		if (!reset_n || !sys_run) begin
			prediv <= 2'h0;
		end else begin
			prediv <= prediv + 2'h1;
		end
	end

	assign sys_tick       = sys_run & (prediv == WDTR_DIV_LAST);
	assign sub_tick       = cfg_sub_rc ? pin_rise[WDTR_LANE_RC] : pin_rise[WDTR_LANE_LXT];
	assign watchdog_clock = cfg_src_sys ? sys_tick : sub_tick;

	// halt clears in every low-power entry; counting resumes on its own
	assign clear_cnt = ~pin_level[WDTR_LANE_PIN] | accept | halt_instr | ~enabled;

	// bits at and above the selected exponent are ignored by the terminal compare
	assign mask     = WDTR_CNT_FULL << ({1'b0, tsel} + WDTR_TSEL_BASE);
	assign overflow = watchdog_clock & ~clear_cnt & ((count | mask) == WDTR_CNT_FULL);

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			count <= '0;
		end else if (clear_cnt) begin
			count <= '0;
		end else if (overflow) begin
			count <= '0;
		end else if (watchdog_clock) begin
			count <= count + 15'h0001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			device_reset_req <= 1'b0;
			pc_sp_reset_req  <= 1'b0;
		end else begin
			device_reset_req <= overflow & ~low_power;
			pc_sp_reset_req  <= overflow & low_power;
		end
	end

	// time-out flag: clear by instruction or halt wins over overflow set, since it masks the overflow
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			timeout_flag <= 1'b0;
		end else if (overflow) begin
			timeout_flag <= 1'b1;
		end else if (accept || halt_instr) begin
			timeout_flag <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			power_down_flag <= 1'b0;
		end else if (halt_instr) begin
			power_down_flag <= 1'b1;
		end else if (accept) begin
			power_down_flag <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			watchdog_enabled <= 1'b0;
			system_clock_run <= 1'b0;
		end else begin
			watchdog_enabled <= enabled;
			system_clock_run <= sys_run;
		end
	end

	// apb slave, zero wait states
	assign pready    = 1'b1;
	assign apb_setup = psel & ~penable;
	assign apb_write = psel & penable & pwrite;

	always_comb begin
		hit_ctrl = 1'b0;
		hit_stat = 1'b0;
		hit_cfg  = 1'b0;
		if (paddr == WDTR_CTRL_OFS) begin
			hit_ctrl = 1'b1;
		end else if (paddr == WDTR_STAT_OFS) begin
			hit_stat = 1'b1;
		end else if (paddr == WDTR_CFG_OFS) begin
			hit_cfg = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			watchdog_control <= WDTR_CTRL_RST;
		end else if (apb_write && hit_ctrl) begin
			watchdog_control <= pwdata[7:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			watchdog_config <= WDTR_CFG_RST;
		end else if (apb_write && hit_cfg) begin
			watchdog_config <= pwdata[3:0];
		end
	end

	// read data and error are captured in the setup cycle
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (apb_setup) begin
			pslverr <= ~(hit_ctrl | hit_stat | hit_cfg);
			if (hit_ctrl) begin
				prdata <= {24'h000000, watchdog_control};
			end else if (hit_stat) begin
				prdata <= {30'h00000000, power_down_flag, timeout_flag};
			end else if (hit_cfg) begin
				prdata <= {28'h0000000, watchdog_config};
			end else begin
				prdata <= 32'h00000000;
			end
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_ovf_normal;
		overflow && !low_power;
	endsequence
	sequence s_ovf_low_power;
		overflow && low_power;
	endsequence
	sequence s_full_reset;
		device_reset_req && !pc_sp_reset_req && timeout_flag;
	endsequence
	sequence s_partial_reset;
		pc_sp_reset_req && !device_reset_req && timeout_flag;
	endsequence

	a_ovf_full_reset: assert property (s_ovf_normal |=> s_full_reset ##1 !device_reset_req)
		else $error("normal overflow did not give one full reset pulse");
	a_ovf_pcsp_reset: assert property (s_ovf_low_power |=> s_partial_reset ##1 !pc_sp_reset_req)
		else $error("low power overflow did not give one pc/sp reset pulse");
	a_ratio_exact: assert property (overflow |-> count == (WDTR_CNT_FULL >> (3'h7 - tsel)))
		else $error("overflow at wrong count");
	a_enable_key: assert property ($past(reset_n) |-> (watchdog_enabled ==
		!(($past(soft_enable_key) == WDTR_KEY_OFF) && !$past(cfg_enable))))
		else $error("enable does not follow option and key");
	a_reset_key: assert property ($rose(reset_n) |-> soft_enable_key == 4'hA)
		else $error("key not 1010 after reset");
	a_clear_zero: assert property (clear_cnt |=> count == 15'h0000 ##1 (count <= 15'h0001))
		else $error("counter not restarted from zero");
	a_disabled_noop: assert property ((!enabled && !halt_instr) |=> $stable(power_down_flag)
		&& count == 15'h0000)
		else $error("disabled watchdog reacted");
	a_sys_stop: assert property ((cfg_src_sys && !sys_run && !clear_cnt) |=> $stable(count))
		else $error("counter moved with system clock stopped");
	a_idle_keep_on: assert property ((idle_mode && !sleep_mode && idle_sysclk_keep_on)
		|=> system_clock_run)
		else $error("system clock stopped in idle with keep-on");
	a_halt_pdf: assert property (halt_instr |=> (power_down_flag && !timeout_flag))
		else $error("halt did not set power-down flag");
	a_count_step: assert property ((watchdog_clock && !clear_cnt && !overflow)
		|=> count == $past(count) + 15'h0001)
		else $error("counter did not step on watchdog clock");
	a_sub_select: assert property ((!cfg_src_sys && cfg_sub_rc) |->
		(watchdog_clock == pin_rise[WDTR_LANE_RC]))
		else $error("rc oscillator not selected as sub clock");

	a_sub_crystal: assert property ((!cfg_src_sys && !cfg_sub_rc) |->
		(watchdog_clock == pin_rise[WDTR_LANE_LXT]))
		else $error("crystal oscillator not selected as sub clock");

	a_req_exclusive: assert property (!(device_reset_req && pc_sp_reset_req))
		else $error("full and pc/sp reset requested together");

	a_ovf_restart: assert property (overflow |=> count == 15'h0000)
		else $error("counter did not restart after overflow");

	a_count_hold: assert property ((!watchdog_clock && !clear_cnt) |=> $stable(count))
		else $error("counter moved without a watchdog clock tick");

	a_pin_clear: assert property (!pin_level[WDTR_LANE_PIN] |=> count == 15'h0000)
		else $error("reset pin low did not hold the counter");

	a_accept_flags: assert property ((accept && !halt_instr) |=>
		(!power_down_flag && !timeout_flag))
		else $error("accepted clear left a flag set");

	a_idle_stop: assert property ((idle_mode && !sleep_mode && !idle_sysclk_keep_on)
		|=> !system_clock_run)
		else $error("system clock kept in idle without keep-on");

	a_sleep_stop: assert property (sleep_mode |=> (!system_clock_run && prediv == 2'h0))
		else $error("system clock or divider ran in sleep");

	// cycles since the last divided system clock tick; never beyond the divide ratio while running
	logic [2:0] tick_gap;

	always_ff @(posedge core_clk) begin
		if (!reset_n || !sys_run || sys_tick) begin
			tick_gap <= 3'h0;
		end else if (tick_gap != 3'h7) begin
			tick_gap <= tick_gap + 3'h1;
		end
	end

	a_sys_tick_gap: assert property (tick_gap <= {1'b0, WDTR_DIV_LAST})
		else $error("divided system clock tick missing");

	sequence s_ctrl_write;
		apb_write && hit_ctrl;
	endsequence
	sequence s_unmapped_setup;
		apb_setup && !(hit_ctrl || hit_stat || hit_cfg);
	endsequence

	a_ctrl_write: assert property (s_ctrl_write |=> watchdog_control == $past(pwdata[7:0]))
		else $error("control write did not land");

	a_unmapped_err: assert property (s_unmapped_setup |=> (pslverr && prdata == 32'h00000000))
		else $error("unmapped address not refused");
endmodule

//--- include/wdtr_clr_if.sv
// wdtr_clr_if: clear instruction strobes and the accept answer between top and clear logic.
// assumes strobes are one-cycle pulses on core_clk.
`timescale 1ns/10ps
interface wdtr_clr_if (
	input wire logic core_clk,
	input wire logic reset_n
);
	logic single;
	logic first;
	logic second;
	logic enabled;
	logic paired;
	logic accept;

	modport ctl (
		input  core_clk,
		input  reset_n,
		input  single,
		input  first,
		input  second,
		input  enabled,
		input  paired,
		output accept
	);
	modport top (
		output single,
		output first,
		output second,
		output enabled,
		output paired,
		input  accept
	);
endinterface

//--- include/wdtr_pkg.sv
// wdtr_pkg: register map, field positions, reset values and counts for the watchdog block.
// assumes a 32-bit apb with byte addresses; registers sit in the low bits of each word.
package wdtr_pkg;
	localparam logic [11:0] WDTR_CTRL_OFS = 12'h000;
	localparam logic [11:0] WDTR_STAT_OFS = 12'h004;
	localparam logic [11:0] WDTR_CFG_OFS  = 12'h008;

	// control register
	localparam logic [7:0] WDTR_CTRL_RST    = 8'h7A;
	localparam int         WDTR_KEEP_ON_BIT = 7;
	localparam int         WDTR_TSEL_MSB    = 6;
	localparam int         WDTR_TSEL_LSB    = 4;
	localparam int         WDTR_KEY_MSB     = 3;
	localparam logic [3:0] WDTR_KEY_OFF     = 4'hA;

	// configuration register
	localparam logic [3:0] WDTR_CFG_RST     = 4'h5;
	localparam int         WDTR_CFG_EN_BIT  = 0;
	localparam int         WDTR_CFG_SYS_BIT = 1;
	localparam int         WDTR_CFG_RC_BIT  = 2;
	localparam int         WDTR_CFG_PAIR_BIT = 3;

	// status register
	localparam int WDTR_STAT_TO_BIT  = 0;
	localparam int WDTR_STAT_PDF_BIT = 1;

	// counter: 2^(base+code) watchdog clock periods
	localparam int          WDTR_CNT_W     = 15;
	localparam logic [14:0] WDTR_CNT_FULL  = 15'h7FFF;
	localparam logic [3:0]  WDTR_TSEL_BASE = 4'h8;
	localparam int          WDTR_SYS_DIV   = 4;
	localparam logic [1:0]  WDTR_DIV_LAST  = 2'(WDTR_SYS_DIV - 1);

	// synchroniser lanes
	localparam int WDTR_LANE_LXT = 0;
	localparam int WDTR_LANE_RC  = 1;
	localparam int WDTR_LANE_PIN = 2;

	typedef enum logic [1:0] {
		WDTR_LAST_NONE,
		WDTR_LAST_FIRST,
		WDTR_LAST_SECOND
	} wdtr_pair_t;
endpackage

//--- verif/watchdog_timeout_reset_tb_top.sv
// watchdog_timeout_reset_tb_top: self-checking bench for wdtr_top over apb and cpu strobes.
// assumes zero-wait apb slave and the cpu model in wdtr_cpu_model.
`timescale 1ns/10ps
module watchdog_timeout_reset_tb_top;
	import wdtr_pkg::*;
	logic        core_clk;
	logic        reset_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready, pslverr, ext_pin_n;
	logic        instr_valid;
	logic [1:0]  instr_op;
	logic [1:0]  power_mode;
	logic        c_single, c_first, c_second, c_halt, c_sleep, c_idle;
	logic        sys_run, dev_req, pcsp_req, to_flag, pd_flag, wd_en;
	logic [2:0]  xtal_cnt;
	logic [1:0]  rc_cnt;
	logic        rc_level;
	int          miscompares = 0;
	int          n_compared = 0;
	int          cycles = 0;

	wdtr_cpu_model i_cpu (.instr_valid(instr_valid), .instr_op(instr_op), .power_mode(power_mode),
		.clear_single_instr(c_single), .clear_pair_first_instr(c_first), .clear_pair_second_instr(c_second),
		.halt_instr(c_halt), .sleep_mode(c_sleep), .idle_mode(c_idle));

	wdtr_top i_dut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.low_speed_crystal_osc(xtal_cnt[2]), .low_speed_rc_osc(rc_level), .external_reset_pin_n(ext_pin_n),
		.clear_single_instr(c_single), .clear_pair_first_instr(c_first), .clear_pair_second_instr(c_second),
		.halt_instr(c_halt), .sleep_mode(c_sleep), .idle_mode(c_idle), .system_clock_run(sys_run),
		.device_reset_req(dev_req), .pc_sp_reset_req(pcsp_req), .timeout_flag(to_flag),
		.power_down_flag(pd_flag), .watchdog_enabled(wd_en));

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// crystal period 8 cycles, rc period 6 cycles
	always @(posedge core_clk) begin
		xtal_cnt <= xtal_cnt + 3'h1;
		rc_cnt <= (rc_cnt == 2'h2) ? 2'h0 : rc_cnt + 2'h1;
		if (rc_cnt == 2'h2) rc_level <= ~rc_level;
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			miscompares++;
			close_out();
		end
	end

	task automatic close_out();
		if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk("prdata", exp, q);
		chk("pslverr", {31'h0, experr}, {31'h0, e});
	endtask

	// kind: 0 full reset request, 1 pc/sp request, 2 nothing within hi cycles
	task automatic ev(input int lo, input int hi, input int kind);
		int n;
		n = 0;
		while (n < hi && dev_req !== 1'b1 && pcsp_req !== 1'b1) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk("reset_request_kind", kind, pcsp_req === 1'b1 ? 1 : dev_req === 1'b1 ? 0 : 2);
		if (kind != 2) chk("overflow_in_window", 1, {31'h0, n >= lo});
	endtask

	task automatic settle();
		repeat (3) @(posedge core_clk);
		#1;
	endtask

	// one instruction strobe: raised after one edge, taken and dropped at the next
	task automatic exec(input logic [1:0] op);
		@(posedge core_clk);
		instr_valid <= 1'b1;
		instr_op <= op;
		@(posedge core_clk);
		instr_valid <= 1'b0;
	endtask

	task automatic set_mode(input logic slp, input logic idl);
		@(posedge core_clk);
		power_mode <= {slp, idl};
	endtask

	initial begin
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		ext_pin_n = 1'b1;
		instr_valid = 1'b0;
		instr_op = 2'h0;
		power_mode = 2'h0;
		xtal_cnt = 3'h0;
		rc_cnt = 2'h0;
		rc_level = 1'b0;
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (5) @(posedge core_clk);
		rd(WDTR_CTRL_OFS, 32'h7A, 1'b0);
		rd(WDTR_CFG_OFS, 32'h5, 1'b0);
		rd(WDTR_STAT_OFS, 32'h0, 1'b0);
		rd(12'h00C, 32'h0, 1'b1);
		wr(WDTR_STAT_OFS, 32'h3);
		rd(WDTR_STAT_OFS, 32'h0, 1'b0);
		wr(WDTR_CFG_OFS, 32'h3);
		for (int sel = 0; sel < 5; sel++) begin
			wr(WDTR_CTRL_OFS, 32'h5 | (sel << 4));
			exec(2'h0);
			ev((1024 << sel) - 12, (1024 << sel) + 12, 0);
			chk("timeout_flag", 1, to_flag);
		end
		rd(WDTR_STAT_OFS, 32'h1, 1'b0);
		wr(WDTR_CTRL_OFS, 32'h85);
		rd(WDTR_CTRL_OFS, 32'h85, 1'b0);
		exec(2'h3);
		#1;
		chk("power_down_flag", 1, pd_flag);
		chk("timeout_flag", 0, to_flag);
		rd(WDTR_STAT_OFS, 32'h2, 1'b0);
		set_mode(1'b0, 1'b1);
		settle();
		chk("system_clock_run", 1, sys_run);
		ev(1005, 1037, 1);
		rd(WDTR_STAT_OFS, 32'h3, 1'b0);
		wr(WDTR_CTRL_OFS, 32'h05);
		exec(2'h3);
		settle();
		chk("system_clock_run", 0, sys_run);
		ev(0, 1500, 2);
		set_mode(1'b0, 1'b0);
		exec(2'h0);
		#1;
		chk("timeout_flag", 0, to_flag);
		chk("power_down_flag", 0, pd_flag);
		repeat (800) @(posedge core_clk);
		exec(2'h0);
		ev(1013, 1037, 0);
		wr(WDTR_CFG_OFS, 32'hB);
		for (int k = 1; k < 3; k++) begin
			exec(2'(k));
			repeat (600) @(posedge core_clk);
			exec(2'(k));
			ev(411, 435, 0);
		end
		exec(2'h1);
		repeat (600) @(posedge core_clk);
		exec(2'h2);
		ev(1013, 1037, 0);
		wr(WDTR_CFG_OFS, 32'h1);
		exec(2'h0);
		set_mode(1'b1, 1'b0);
		ev(2038, 2072, 1);
		wr(WDTR_CFG_OFS, 32'h5);
		exec(2'h0);
		ev(1526, 1560, 1);
		set_mode(1'b0, 1'b0);
		wr(WDTR_CFG_OFS, 32'h3);
		exec(2'h0);
		@(posedge core_clk);
		ext_pin_n <= 1'b0;
		ev(0, 1500, 2);
		ext_pin_n <= 1'b1;
		ev(1013, 1040, 0);
		wr(WDTR_CFG_OFS, 32'h2);
		wr(WDTR_CTRL_OFS, 32'h0A);
		settle();
		chk("watchdog_enabled", 0, wd_en);
		exec(2'h3);
		exec(2'h0);
		#1;
		chk("power_down_flag", 1, pd_flag);
		ev(0, 1500, 2);
		wr(WDTR_CTRL_OFS, 32'h05);
		settle();
		chk("watchdog_enabled", 1, wd_en);
		wr(WDTR_CFG_OFS, 32'h3);
		wr(WDTR_CTRL_OFS, 32'h0A);
		settle();
		chk("watchdog_enabled", 1, wd_en);
		close_out();
	end
endmodule

//--- verif/wdtr_cpu_model.sv
// wdtr_cpu_model: cpu core side decoding clear-watchdog and halt instructions and power-mode levels.
// assumes the bench presents one instruction code per core_clk cycle, changed just after a rising edge.
`timescale 1ns/10ps
module wdtr_cpu_model (
	input  wire logic       instr_valid,
	input  wire logic [1:0] instr_op,
	input  wire logic [1:0] power_mode,
	output logic            clear_single_instr,
	output logic            clear_pair_first_instr,
	output logic            clear_pair_second_instr,
	output logic            halt_instr,
	output logic            sleep_mode,
	output logic            idle_mode
);
	// op 0 single clear, 1 first of pair, 2 second of pair, 3 halt; one strobe at a time
	always_comb begin
		clear_single_instr      = instr_valid && (instr_op == 2'h0);
		clear_pair_first_instr  = instr_valid && (instr_op == 2'h1);
		clear_pair_second_instr = instr_valid && (instr_op == 2'h2);
		halt_instr              = instr_valid && (instr_op == 2'h3);
	end

	// power_mode[1] sleep, power_mode[0] idle
	assign sleep_mode = power_mode[1];
	assign idle_mode  = power_mode[0];
endmodule
